// [rtl/rqc_map.vh]
// Purpose: Register map, field positions and constants of the inventory round controller
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: Definitions only
`ifndef RQC_MAP_VH
`define RQC_MAP_VH

// Register byte offsets
`define RQC_ADR_CTRL 8'h00
`define RQC_ADR_CFG 8'h04
`define RQC_ADR_DYN 8'h08
`define RQC_ADR_DWELL 8'h0C
`define RQC_ADR_STATUS 8'h10
`define RQC_ADR_ROUNDS 8'h14

// Control fields
`define RQC_CTRL_START 0
`define RQC_CTRL_STOP 1
`define RQC_CTRL_CONT 2
`define RQC_CTRL_TOGGLE 3
`define RQC_CTRL_ALG 4

// Configuration fields
`define RQC_CFG_TGT 1:0
`define RQC_CFG_SESS 3:2
`define RQC_CFG_FIXQ 7:4
`define RQC_CFG_INITQ 11:8
`define RQC_DYN_MAXREP 7:0
`define RQC_DYN_UPPER 15:8
`define RQC_DYN_LOWER 23:16
`define RQC_DWELL_MS 15:0
`define RQC_CFG_USED 11:0
`define RQC_DYN_USED 23:0

// Reset values
`define RQC_CFG_RST 32'h0000_0440
`define RQC_DYN_RST 32'h0008_2010
`define RQC_DWELL_RST 16'h0000

// Target flag codes
`define RQC_TGT_A 2'h0
`define RQC_TGT_B 2'h1
`define RQC_TGT_UNK 2'h2

// Slot outcome codes
`define RQC_SLOT_RN16_TO 2'h0
`define RQC_SLOT_EPC_TO 2'h1
`define RQC_SLOT_TAG 2'h2

// Q limits and ratio fraction bits
`define RQC_Q_MAX 4'hF
`define RQC_Q_MIN 4'h0
`define RQC_RATIO_FRAC 4

// Time base
`define RQC_MS_NS 1000000
`define RQC_CLK_NS 10
`define RQC_CYC_PER_MS (`RQC_MS_NS / `RQC_CLK_NS)

`endif

// [rtl/rqc_round_ctrl.v]
// Purpose: Inventory round controller issuing Query and QueryRep with adaptive or constant Q
// Assumes: Modem on the same clock reports one outcome per slot; Wishbone classic slave
// Notes: Stop aborts a round only while a slot outcome is awaited
// Notes on behaviour
// - Target flag in each Query configurable as A, B or unknown.
// - Toggling on in continuous inventory: first round A, then B, alternating.
// - Toggling off: same configured target flag every round.
// - One of four sessions used for the whole round.
// - Q is an integer from 0 to 15 in Query commands.
// - Recommend 2^Q above the largest expected tag count.
// - Two selectable algorithms: constant Q and adaptive Q.
// - Constant Q: each round same Q, attempts all 2^Q slots.
// - Constant-Q round cut off on hop time (session 0) or dwell time.
// - Adaptive round: one Query then at most configured QueryRep count.
// - Decrement Q when RN16 timeouts exceed EPC timeouts times upper ratio.
// - Increment Q when RN16 timeouts below EPC timeouts times lower ratio.
// - Between both products Q stays unchanged.
// - Cycle ends after a round with Q zero reading no tags.
// - Adaptive start Q and constant Q are separate settings.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "rqc_map.vh"

module rqc_round_ctrl #(
	parameter CYC_PER_MS = `RQC_CYC_PER_MS
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Command request to modem
	output reg cmd_valid,
	output reg cmd_rep,
	output reg [1:0] cmd_target,
	output reg [1:0] cmd_session,
	output reg [3:0] cmd_q,
	// Slot outcome from modem
	input wire slot_done,
	input wire [1:0] slot_kind,
	// Frequency hop expiry from hop logic
	input wire hop_expired,
	// Status
	output reg busy
);

	// Sequencer states
	localparam S_IDLE = 2'h0;
	localparam S_ISSUE = 2'h1;
	localparam S_WAIT = 2'h2;
	localparam S_EVAL = 2'h3;

	reg [1:0] state_q;
	// Stored settings
	reg cont_q;
	reg toggle_q;
	reg alg_q;
	reg [31:0] cfg_q;
	reg [31:0] dyn_q;
	reg [15:0] dwell_q;
	// Round state and counters
	reg [3:0] cur_q;
	reg [1:0] cur_tgt_q;
	reg [15:0] slot_idx_q;
	reg [15:0] rn16_cnt_q;
	reg [15:0] epc_cnt_q;
	reg [15:0] tag_cnt_q;
	reg [15:0] last_tags_q;
	reg [31:0] rounds_q;
	// Outcome still owed for a command cut off or stopped
	reg owe_q;
	// Dwell time base
	reg [31:0] ms_div_q;
	reg [15:0] ms_cnt_q;

	// A request is taken once, while ack is low
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = wb_req & wb_we_i & (&wb_sel_i);
	wire wr_ctrl = wr & (wb_adr_i == `RQC_ADR_CTRL);
	wire start = wr_ctrl & wb_dat_i[`RQC_CTRL_START];
	wire stop = wr_ctrl & wb_dat_i[`RQC_CTRL_STOP];

	wire [3:0] fix_q = cfg_q[`RQC_CFG_FIXQ];
	wire [3:0] init_q = cfg_q[`RQC_CFG_INITQ];
	wire [1:0] cfg_tgt = cfg_q[`RQC_CFG_TGT];
	wire [7:0] max_rep = dyn_q[`RQC_DYN_MAXREP];
	wire [7:0] upper = dyn_q[`RQC_DYN_UPPER];
	wire [7:0] lower = dyn_q[`RQC_DYN_LOWER];

	// Outcome of the slot just finished folded into the counters
	wire rn16_hit = slot_done & (slot_kind == `RQC_SLOT_RN16_TO);
	wire epc_hit = slot_done & (slot_kind == `RQC_SLOT_EPC_TO);
	wire tag_hit = slot_done & (slot_kind == `RQC_SLOT_TAG);

	// Last slot of the round
	wire [15:0] fix_last = (16'h0001 << cur_q) - 16'h0001;
	wire last_slot = alg_q ? (slot_idx_q == {8'h00, max_rep})
		: (slot_idx_q == fix_last);

	// Round cut-off on hop in session 0 or dwell expiry, constant Q only
	wire dwell_out = (dwell_q != 16'h0000) & (ms_cnt_q >= dwell_q);
	wire sess0 = (cfg_q[`RQC_CFG_SESS] == 2'h0);
	wire cut = ~alg_q & ((hop_expired & sess0) | dwell_out);

	// Threshold products with fractional ratio
	wire [23:0] rn16_scaled = {4'h0, rn16_cnt_q, 4'h0};
	wire [23:0] up_prod = epc_cnt_q * upper;
	wire [23:0] lo_prod = epc_cnt_q * lower;

	// Q for the next adaptive round
	reg [3:0] next_q;
	always @*
	begin
		next_q = cur_q;
		if (rn16_scaled > up_prod)
		begin
			if (cur_q != `RQC_Q_MIN)
				next_q = cur_q - 4'h1;
		end
		else if (rn16_scaled < lo_prod)
		begin
			if (cur_q != `RQC_Q_MAX)
				next_q = cur_q + 4'h1;
		end
	end

	// Cycle end: adaptive on empty round at Q zero, constant after one round
	wire cycle_end = alg_q ? ((cur_q == 4'h0) & (tag_cnt_q == 16'h0000)) : 1'b1;
	// Start settings come from the very write that starts the cycle
	wire [1:0] first_tgt = wb_dat_i[`RQC_CTRL_TOGGLE] ? `RQC_TGT_A : cfg_tgt;
	wire [1:0] flip_tgt = (cur_tgt_q == `RQC_TGT_A) ? `RQC_TGT_B : `RQC_TGT_A;
	wire [3:0] start_q = alg_q ? init_q : fix_q;
	wire [3:0] launch_q = wb_dat_i[`RQC_CTRL_ALG] ? init_q : fix_q;

	// Register file
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cont_q <= 1'b0;
			toggle_q <= 1'b0;
			alg_q <= 1'b0;
			cfg_q <= `RQC_CFG_RST;
			dyn_q <= `RQC_DYN_RST;
			dwell_q <= `RQC_DWELL_RST;
		end
		else if (wr & (state_q == S_IDLE))
		begin
			if (wb_adr_i == `RQC_ADR_CTRL)
			begin
				cont_q <= wb_dat_i[`RQC_CTRL_CONT];
				toggle_q <= wb_dat_i[`RQC_CTRL_TOGGLE];
				alg_q <= wb_dat_i[`RQC_CTRL_ALG];
			end
			else if (wb_adr_i == `RQC_ADR_CFG)
				cfg_q <= {20'h00000, wb_dat_i[`RQC_CFG_USED]};
			else if (wb_adr_i == `RQC_ADR_DYN)
				dyn_q <= {8'h00, wb_dat_i[`RQC_DYN_USED]};
			else if (wb_adr_i == `RQC_ADR_DWELL)
				dwell_q <= wb_dat_i[`RQC_DWELL_MS];
		end
	end

	// Bus answer one cycle after the request
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req & ~wb_we_i)
			begin
				if (wb_adr_i == `RQC_ADR_CTRL)
					wb_dat_o <= {27'h0000000, alg_q, toggle_q, cont_q, 2'h0};
				else if (wb_adr_i == `RQC_ADR_CFG)
					wb_dat_o <= cfg_q;
				else if (wb_adr_i == `RQC_ADR_DYN)
					wb_dat_o <= dyn_q;
				else if (wb_adr_i == `RQC_ADR_DWELL)
					wb_dat_o <= {16'h0000, dwell_q};
				else if (wb_adr_i == `RQC_ADR_STATUS)
					wb_dat_o <= {last_tags_q, 6'h00, cur_tgt_q, cur_q, 3'h0, busy};
				else if (wb_adr_i == `RQC_ADR_ROUNDS)
					wb_dat_o <= rounds_q;
				else
					wb_dat_o <= 32'h0000_0000;
			end
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	// Dwell timer, restarted at each round
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ms_div_q <= 32'h0000_0000;
			ms_cnt_q <= 16'h0000;
		end
		else if (state_q == S_IDLE || state_q == S_EVAL)
		begin
			ms_div_q <= 32'h0000_0000;
			ms_cnt_q <= 16'h0000;
		end
		else if (ms_div_q == CYC_PER_MS - 1)
		begin
			ms_div_q <= 32'h0000_0000;
			if (ms_cnt_q != 16'hFFFF)
				ms_cnt_q <= ms_cnt_q + 16'h0001;
		end
		else
			ms_div_q <= ms_div_q + 32'h0000_0001;
	end

	// Round sequencer
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			busy <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_rep <= 1'b0;
			cmd_target <= `RQC_TGT_A;
			cmd_session <= 2'h0;
			cmd_q <= 4'h0;
			cur_q <= 4'h0;
			cur_tgt_q <= `RQC_TGT_A;
			slot_idx_q <= 16'h0000;
			rn16_cnt_q <= 16'h0000;
			epc_cnt_q <= 16'h0000;
			tag_cnt_q <= 16'h0000;
			last_tags_q <= 16'h0000;
			rounds_q <= 32'h0000_0000;
			owe_q <= 1'b0;
		end
		else
		begin
			cmd_valid <= 1'b0;
			if (slot_done)
				owe_q <= 1'b0;
			case (state_q)
			S_IDLE:
			begin
				busy <= 1'b0;
				// Start clears the round counters
				if (start)
				begin
					busy <= 1'b1;
					cur_q <= launch_q;
					cur_tgt_q <= first_tgt;
					slot_idx_q <= 16'h0000;
					rn16_cnt_q <= 16'h0000;
					epc_cnt_q <= 16'h0000;
					tag_cnt_q <= 16'h0000;
					state_q <= S_ISSUE;
				end
			end
			S_ISSUE:
			begin
				// Hold off until a stale outcome has come in
				if (~owe_q | slot_done)
				begin
					cmd_valid <= 1'b1;
					cmd_rep <= (slot_idx_q != 16'h0000);
					cmd_target <= cur_tgt_q;
					cmd_session <= cfg_q[`RQC_CFG_SESS];
					cmd_q <= cur_q;
					state_q <= S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (rn16_hit)
					rn16_cnt_q <= rn16_cnt_q + 16'h0001;
				if (epc_hit)
					epc_cnt_q <= epc_cnt_q + 16'h0001;
				if (tag_hit)
					tag_cnt_q <= tag_cnt_q + 16'h0001;
				if (stop)
				begin
					owe_q <= ~slot_done;
					state_q <= S_IDLE;
				end
				else if (cut)
				begin
					owe_q <= ~slot_done;
					state_q <= S_EVAL;
				end
				else if (slot_done)
				begin
					if (last_slot)
						state_q <= S_EVAL;
					else
					begin
						slot_idx_q <= slot_idx_q + 16'h0001;
						state_q <= S_ISSUE;
					end
				end
			end
			S_EVAL:
			begin
				// Close the round and choose the next Q
				rounds_q <= rounds_q + 32'h0000_0001;
				last_tags_q <= tag_cnt_q;
				slot_idx_q <= 16'h0000;
				rn16_cnt_q <= 16'h0000;
				epc_cnt_q <= 16'h0000;
				tag_cnt_q <= 16'h0000;
				if (toggle_q)
					cur_tgt_q <= flip_tgt;
				if (cycle_end)
					cur_q <= start_q;
				else
					cur_q <= next_q;
				if (cycle_end & ~cont_q)
					state_q <= S_IDLE;
				else
					state_q <= S_ISSUE;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

endmodule // rqc_round_ctrl

// [testbench/rqc_round_ctrl_asserts.sv]
// Purpose: Port-level assertions of the inventory round controller
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every controller instance
`timescale 1ns/10ps
module rqc_round_ctrl_chk (
	// Clock and reset
	input logic ref_clk,
	input logic rst_n,
	// Bus
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	// Commands and slots
	input logic cmd_valid,
	input logic cmd_rep,
	input logic [1:0] cmd_target,
	input logic [1:0] cmd_session,
	input logic [3:0] cmd_q,
	input logic slot_done,
	input logic busy
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	cmd_once_a: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse too long");
	cmd_busy_a: assert property (cmd_valid |-> busy)
		else $error("command while idle");
	field_hold_a:
		assert property (!cmd_valid |-> $stable({cmd_rep, cmd_target, cmd_session, cmd_q}))
		else $error("command fields moved");
	round_keep_a:
		assert property (cmd_valid && cmd_rep |-> $stable({cmd_target, cmd_session, cmd_q}))
		else $error("round fields changed");
	rep_after_slot_a:
		assert property (cmd_valid && cmd_rep |-> $past(slot_done) || $past(slot_done, 2)
			|| $past(slot_done, 3))
		else $error("repeat without slot outcome");
endmodule // rqc_round_ctrl_chk
bind rqc_round_ctrl rqc_round_ctrl_chk u_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.cmd_valid(cmd_valid),
	.cmd_rep(cmd_rep),
	.cmd_target(cmd_target),
	.cmd_session(cmd_session),
	.cmd_q(cmd_q),
	.slot_done(slot_done),
	.busy(busy)
);

// [testbench/rqc_tag_model.sv]
// Purpose: Behavioural tag population answering each command
// Assumes: One outcome per command after a fixed delay
// Notes: Slot picks are a fixed hash; one flag per tag
`timescale 1ns/10ps
`include "rqc_map.vh"
module rqc_tag_model #(
	parameter int NT = 6,
	parameter int DLY = 3
) (
	// Clock and reset
	input logic ref_clk,
	input logic rst_n,
	// Commands
	input logic cmd_valid,
	input logic cmd_rep,
	input logic [1:0] cmd_target,
	input logic [3:0] cmd_q,
	// Slot outcome
	output logic slot_done,
	output logic [1:0] slot_kind
);
	logic fl[NT];
	logic [15:0] sc[NT];
	int wt, n, hit;
	always @(posedge ref_clk)
	begin
		slot_done <= 1'b0;
		slot_kind <= 2'h3;
		if (!rst_n)
		begin
			foreach (fl[i])
				fl[i] = 1'b0;
			wt = 0;
		end
		else if (cmd_valid)
		begin
			n = 0;
			foreach (sc[i])
			begin
				if (!cmd_rep)
					sc[i] = (cmd_target == `RQC_TGT_UNK || fl[i] == cmd_target[0]) ?
						16'(i * 7 + 3) & ((16'h1 << cmd_q) - 16'h1) : 16'hFFFF;
				else if (sc[i] != 16'hFFFF)
					sc[i] = sc[i] - 16'h1;
				if (sc[i] == 16'h0)
				begin
					n++;
					hit = i;
				end
			end
			wt = DLY;
		end
		else if (wt > 0)
		begin
			wt--;
			if (wt == 0)
			begin
				slot_done <= 1'b1;
				slot_kind <= n == 0 ? `RQC_SLOT_RN16_TO : n == 1 ? `RQC_SLOT_TAG : `RQC_SLOT_EPC_TO;
				if (n == 1)
					fl[hit] = 1'b1;
			end
		end
	end
endmodule // rqc_tag_model

// [testbench/rqc_round_ctrl_tb.sv]
// Purpose: Self-checking bench of the inventory round controller
// Assumes: Tag model answers every command after a fixed delay
// Notes: Millisecond count shortened to ten cycles
`timescale 1ns/10ps
`include "rqc_map.vh"
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("Error %0t: got %0h exp %0h", $time, g, e); \
		end \
	end
module rqc_round_ctrl_tb;
	logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hop_expired, busy;
	logic cmd_valid, cmd_rep, slot_done;
	logic [1:0] cmd_target, cmd_session, slot_kind;
	logic [3:0] cmd_q;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic [3:0] qq[$], tq[$];
	wire [3:0] wb_sel_i = 4'hF;
	int err_total, num_checks, ncmd, rc, rmax;
	rqc_round_ctrl #(.CYC_PER_MS(10)) i_dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.cmd_valid(cmd_valid),
		.cmd_rep(cmd_rep),
		.cmd_target(cmd_target),
		.cmd_session(cmd_session),
		.cmd_q(cmd_q),
		.slot_done(slot_done),
		.slot_kind(slot_kind),
		.hop_expired(hop_expired),
		.busy(busy)
	);
	rqc_tag_model i_tags (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cmd_valid(cmd_valid),
		.cmd_rep(cmd_rep),
		.cmd_target(cmd_target),
		.cmd_q(cmd_q),
		.slot_done(slot_done),
		.slot_kind(slot_kind)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Record every command issued
	always @(posedge ref_clk)
		if (cmd_valid === 1'b1)
		begin
			ncmd++;
			rc++;
			if (cmd_rep !== 1'b1)
			begin
				qq.push_back(cmd_q);
				tq.push_back({cmd_session, cmd_target});
				rc = 0;
			end
			rmax = rc > rmax ? rc : rmax;
		end
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do
		begin
			@(posedge ref_clk);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Start a cycle; stop it once lim queries were seen
	task automatic go(input logic [31:0] c, input int lim);
		int n;
		qq.delete();
		tq.delete();
		ncmd = 0;
		rmax = 0;
		wb(`RQC_ADR_CTRL, 1'b1, c);
		n = 0;
		while ((busy === 1'b1 || n < 3) && n < 3000)
		begin
			if (qq.size() >= lim)
				wb(`RQC_ADR_CTRL, 1'b1, 32'h2);
			else
				@(posedge ref_clk);
			n++;
		end
		if (n >= 3000)
		begin
			err_total++;
			tally_and_finish;
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		hop_expired = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		wb(`RQC_ADR_CFG, 1'b0, 32'h0);
		`CHK(rdat, `RQC_CFG_RST)
		wb(`RQC_ADR_DYN, 1'b0, 32'h0);
		`CHK(rdat, `RQC_DYN_RST)
		wb(8'h1C, 1'b0, 32'h0);
		`CHK(rdat, 32'h0)
		for (int t = 0; t < 3; t++)
		begin
			wb(`RQC_ADR_CFG, 1'b1, t | t << 2 | (t + 1) << 4);
			go(32'h1, 99);
			`CHK(ncmd, 2 << t)
			foreach (tq[i])
				`CHK(tq[i], 4'(t * 5))
		end
		for (int g = 0; g < 2; g++)
		begin
			wb(`RQC_ADR_CFG, 1'b1, 32'h11);
			go(32'h5 | g << 3, 4);
			for (int i = 0; i < 4; i++)
				`CHK(tq[i][1:0], g ? 2'(i % 2) : 2'h1)
		end
		for (int k = 0; k < 2; k++)
		begin
			wb(`RQC_ADR_CFG, 1'b1, k ? 32'h40 : 32'h44);
			wb(`RQC_ADR_DWELL, 1'b1, 32'(1 - k));
			hop_expired <= k[0];
			go(32'h1, 99);
			hop_expired <= 1'b0;
			`CHK(ncmd < 16, 1'b1)
		end
		// Second reset returns every tag to flag A
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		wb(`RQC_ADR_CFG, 1'b1, 32'h301);
		wb(`RQC_ADR_DYN, 1'b1, 32'h1002);
		go(32'h11, 99);
		`CHK(qq.size(), 4)
		foreach (qq[i])
			`CHK(qq[i], 4'(3 - i))
		`CHK(rmax <= 2, 1'b1)
		wb(`RQC_ADR_STATUS, 1'b0, 32'h0);
		`CHK(rdat, 32'h0000_0130)
		wb(`RQC_ADR_ROUNDS, 1'b0, 32'h0);
		`CHK(rdat, 32'h4)
		wb(`RQC_ADR_CTRL, 1'b0, 32'h0);
		`CHK(rdat, 32'h10)
		for (int j = 0; j < 2; j++)
		begin
			wb(`RQC_ADR_CFG, 1'b1, 32'h100);
			wb(`RQC_ADR_DYN, 1'b1, j ? 32'hFF02 : 32'h10FF02);
			go(32'h11, 2);
			`CHK(qq[1], 4'(2 - j))
		end
		tally_and_finish;
	end
endmodule // rqc_round_ctrl_tb
